// File: hdl/dcs_pkg.sv
// Package holding offsets, field positions and reset values of the control and status bank
package dcs_pkg;
   // Register offsets on the configuration port
   localparam logic [3:0] OFS_SYNC_ERR = 4'h3;
   localparam logic [3:0] OFS_ERR_STAT = 4'h4;
   localparam logic [3:0] OFS_IF_CLK   = 4'h5;
   localparam logic [3:0] OFS_POWER    = 4'h6;
   localparam logic [3:0] OFS_GAIN     = 4'h7;
   localparam logic [3:0] OFS_RESTART  = 4'h8;
   localparam logic [3:0] OFS_LOCKSTAT = 4'h0;
   // Values after reset
   localparam logic [7:0] RST_SYNC_ERR = 8'h70;
   localparam logic [7:0] RST_ERR_STAT = 8'h00;
   localparam logic [7:0] RST_IF_CLK   = 8'h00;
   localparam logic [7:0] RST_POWER    = 8'h0c;
   localparam logic [7:0] RST_GAIN     = 8'hff;
   localparam logic [7:0] RST_RESTART  = 8'h00;
   // Writable masks per register
   localparam logic [7:0] WM_SYNC_ERR  = 8'hf3;
   localparam logic [7:0] WM_IF_CLK    = 8'he6;
   localparam logic [7:0] WM_POWER     = 8'h1b;
   localparam logic [7:0] WM_GAIN      = 8'hf0;
   localparam logic [7:0] WM_RESTART   = 8'h04;
   // Field positions
   localparam int B_OFS_EN    = 7;
   localparam int B_SELF_MASK = 6;
   localparam int B_OVR_MASK  = 5;
   localparam int B_CHK_MASK  = 4;
   localparam int B_SSYNC     = 1;
   localparam int B_SSYNC_SEL = 0;
   localparam int B_SELF_FLAG = 6;
   localparam int B_OVR_FLAG  = 5;
   localparam int B_CHK_FLAG  = 4;
   localparam int B_FOUR_WIRE = 7;
   localparam int B_REV_BUS   = 6;
   localparam int B_DIVS_DIS  = 5;
   localparam int B_DLY_BYP   = 2;
   localparam int B_MUL_BYP   = 1;
   localparam int B_CNV_SLEEP = 4;
   localparam int B_BIAS_SEL  = 3;
   localparam int B_MUL_SLEEP = 1;
   localparam int B_DLY_SLEEP = 0;
   localparam int B_RESTART   = 2;
   localparam int B_LOCKED    = 6;
   // Checkerboard words
   localparam logic [15:0] CHK_WORD_A = 16'haaaa;
   localparam logic [15:0] CHK_WORD_B = 16'h5555;
   // Delay loop acquisition cycles after restart release
   localparam logic [7:0] LOCK_CYCLES = 8'h20;
   // Mid-range delay line code
   localparam logic [3:0] DLY_MID = 4'h8;
endpackage

// File: hdl/dcs_bit_rev.sv
// Optional bit order swap of the input data bus
`timescale 1ns/1ps
module dcs_bit_rev (
   input  wire logic        enable,
   input  wire logic [15:0] din,
   output logic      [15:0] dout
);
   // Mirror each bit position when enabled
   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_rev
         assign dout[i] = enable ? din[15 - i] : din[i];
      end
   endgenerate
endmodule

// File: hdl/dcs_lock_track.sv
// Delay loop restart and lock acquisition tracker
`timescale 1ns/1ps
module dcs_lock_track (
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       restart,
   input  wire logic       loop_off,
   input  wire logic       clk_present,
   output logic            locked,
   output logic            filter_reset,
   output logic      [3:0] delay_code
);
   typedef enum logic [1:0] {DCS_HOLD = 2'b00, DCS_ACQ = 2'b01, DCS_LOCK = 2'b11} dcs_lk_t;
   dcs_lk_t     state;
   dcs_lk_t     next_state;
   logic [7:0]  cnt;
   logic [3:0]  next_code;
   // Next state selection
   always_comb begin
      next_state = state;
      case (state)
         DCS_HOLD: next_state = (restart || loop_off || !clk_present) ?
                                DCS_HOLD : DCS_ACQ;
         DCS_ACQ:  next_state = (restart || loop_off || !clk_present) ? DCS_HOLD :
                                (cnt == dcs_pkg::LOCK_CYCLES) ? DCS_LOCK : DCS_ACQ;
         DCS_LOCK: next_state = (restart || loop_off || !clk_present) ? DCS_HOLD : DCS_LOCK;
         default:  next_state = DCS_HOLD;
      endcase
   end
   assign next_code = (next_state == DCS_HOLD) ? dcs_pkg::DLY_MID : delay_code;
   // State, counter and outputs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state        <= DCS_HOLD;
         cnt          <= 8'h00;
         locked       <= 1'b0;
         filter_reset <= 1'b1;
         delay_code   <= dcs_pkg::DLY_MID;
      end else begin
         state        <= next_state;
         cnt          <= (next_state == DCS_ACQ) ? cnt + 8'h01 : 8'h00;
         locked       <= (next_state == DCS_LOCK);
         filter_reset <= (next_state == DCS_HOLD);
         delay_code   <= next_code;
      end
   end
   a_restart_unlock: assert property (@(posedge sys_clk) disable iff (srst)
      restart |=> !locked && filter_reset && delay_code == dcs_pkg::DLY_MID)
      else $error("restart did not clear lock");
   a_lock_after_acq: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(locked) |-> $past(state) == DCS_ACQ)
      else $error("lock without acquisition");
endmodule

// File: hdl/dcs_regs.sv
// Control and status register bank of the converter with its steered datapath hooks
`timescale 1ns/1ps
// Operation
// - Offset enable adds offset to channel samples
// - Masks hide flags; masks reset high
// - Soft sync is ORed with external sync input
// - Soft sync select ignores external pins
// - Selftest fail sets flag, shown on pin
// - Buffer overrun sets overrun flag
// - Unmasked checker flags non checkerboard words
// - Four wire select picks serial mode
// - Bit reverse swaps input bus order
// - Bypass bits skip delay loop, multiplier
// - Sleep bits power down three blocks
// - Bias filter select picks corner
// - Gain field scales current sixteen steps
// - Restart resets filter, centres delay, unlocks
// - Release of restart starts lock acquisition
// - Locked status shows loop lock
module dcs_regs (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [3:0]  addr,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata,
   input  wire logic        ext_sync_pin,
   input  wire logic        source_data_clock_present,
   input  wire logic        selftest_enable,
   input  wire logic        selftest_fail,
   input  wire logic        overrun_event,
   input  wire logic        buf_word_valid,
   input  wire logic [15:0] buf_word,
   input  wire logic [15:0] in_bus,
   input  wire logic [12:0] offset_value_a,
   input  wire logic [15:0] sample_a,
   input  wire logic        serial_out_normal,
   output logic      [15:0] bus_ordered,
   output logic      [15:0] sample_a_out,
   output logic             sync_event,
   output logic             tx_enable,
   output logic             divider_sync,
   output logic             four_wire_select,
   output logic             delay_loop_bypass,
   output logic             multiplier_bypass,
   output logic             converter_sleep,
   output logic             multiplier_sleep,
   output logic             delay_loop_sleep,
   output logic             bias_filter_select,
   output logic      [3:0]  output_current_scale,
   output logic      [4:0]  current_steps,
   output logic             delay_filter_reset,
   output logic      [3:0]  delay_line_code,
   output logic             serial_data_output_pin
);
   // Storage of the writable registers
   logic [7:0]  sync_and_error_control;
   logic [7:0]  interface_clocking_control;
   logic [7:0]  power_down_control;
   logic [7:0]  output_gain_control;
   logic [7:0]  delay_loop_restart_control;
   logic [7:0]  error_status;
   logic [2:0]  raw_flags;
   logic        delay_loop_locked;
   // Two-stage synchronisers for pin inputs
   logic [1:0]  sync_pin_ff;
   logic [1:0]  clk_pres_ff;
   logic        sync_level_q;
   logic [7:0]  next_error_status;
   logic [2:0]  next_raw;
   logic [7:0]  read_mux;
   logic [15:0] ordered_raw;

   // Address decode strobes
   wire we_sync = wr_en && (addr == dcs_pkg::OFS_SYNC_ERR);
   wire we_err  = wr_en && (addr == dcs_pkg::OFS_ERR_STAT);
   wire we_if   = wr_en && (addr == dcs_pkg::OFS_IF_CLK);
   wire we_pwr  = wr_en && (addr == dcs_pkg::OFS_POWER);
   wire we_gain = wr_en && (addr == dcs_pkg::OFS_GAIN);
   wire we_rst  = wr_en && (addr == dcs_pkg::OFS_RESTART);

   // Control field taps
   wire offset_add_enable     = sync_and_error_control[dcs_pkg::B_OFS_EN];
   wire selftest_fail_mask    = sync_and_error_control[dcs_pkg::B_SELF_MASK];
   wire overrun_error_mask    = sync_and_error_control[dcs_pkg::B_OVR_MASK];
   wire checker_mismatch_mask = sync_and_error_control[dcs_pkg::B_CHK_MASK];
   wire soft_sync             = sync_and_error_control[dcs_pkg::B_SSYNC];
   wire soft_sync_select      = sync_and_error_control[dcs_pkg::B_SSYNC_SEL];
   wire bit_order_reverse     = interface_clocking_control[dcs_pkg::B_REV_BUS];
   wire divider_sync_disable  = interface_clocking_control[dcs_pkg::B_DIVS_DIS];
   wire delay_loop_restart    = delay_loop_restart_control[dcs_pkg::B_RESTART];

   // Sync source selection and event derivation
   wire sync_level = soft_sync_select ? soft_sync : (soft_sync | sync_pin_ff[1]);
   assign sync_event   = sync_level && !sync_level_q;
   assign tx_enable    = sync_level;
   assign divider_sync = sync_event && !divider_sync_disable;

   // Control outputs steered by registers
   assign four_wire_select     = interface_clocking_control[dcs_pkg::B_FOUR_WIRE];
   assign delay_loop_bypass    = interface_clocking_control[dcs_pkg::B_DLY_BYP];
   assign multiplier_bypass    = interface_clocking_control[dcs_pkg::B_MUL_BYP];
   assign converter_sleep      = power_down_control[dcs_pkg::B_CNV_SLEEP];
   assign multiplier_sleep     = power_down_control[dcs_pkg::B_MUL_SLEEP];
   assign delay_loop_sleep     = power_down_control[dcs_pkg::B_DLY_SLEEP];
   assign bias_filter_select   = power_down_control[dcs_pkg::B_BIAS_SEL];
   assign output_current_scale = output_gain_control[7:4];
   assign current_steps        = {1'b0, output_gain_control[7:4]} + 5'h01;

   // Checker match on words leaving the buffer
   wire word_bad = buf_word_valid && !checker_mismatch_mask &&
                   (buf_word != dcs_pkg::CHK_WORD_A) && (buf_word != dcs_pkg::CHK_WORD_B);

   // Sticky raw flags: event wins over a clearing write
   always_comb begin
      next_raw = raw_flags;
      if (we_err) begin
         next_raw[2] = raw_flags[2] & wdata[dcs_pkg::B_SELF_FLAG];
         next_raw[1] = raw_flags[1] & wdata[dcs_pkg::B_OVR_FLAG];
         next_raw[0] = raw_flags[0] & wdata[dcs_pkg::B_CHK_FLAG];
      end
      if (selftest_fail) next_raw[2] = 1'b1;
      if (overrun_event) next_raw[1] = 1'b1;
      if (word_bad)      next_raw[0] = 1'b1;
   end

   // Visible status with masks applied
   always_comb begin
      next_error_status = 8'h00;
      next_error_status[dcs_pkg::B_SELF_FLAG] = next_raw[2] & !selftest_fail_mask;
      next_error_status[dcs_pkg::B_OVR_FLAG]  = next_raw[1] & !overrun_error_mask;
      next_error_status[dcs_pkg::B_CHK_FLAG]  = next_raw[0] & !checker_mismatch_mask;
   end

   // Register writes honour writable bit masks; reserved bits keep reset values
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync_and_error_control     <= dcs_pkg::RST_SYNC_ERR;
         interface_clocking_control <= dcs_pkg::RST_IF_CLK;
         power_down_control         <= dcs_pkg::RST_POWER;
         output_gain_control        <= dcs_pkg::RST_GAIN;
         delay_loop_restart_control <= dcs_pkg::RST_RESTART;
      end else begin
         if (we_sync)
            sync_and_error_control <= wdata & dcs_pkg::WM_SYNC_ERR;
         if (we_if)
            interface_clocking_control <= wdata & dcs_pkg::WM_IF_CLK;
         if (we_pwr)
            power_down_control <= (wdata & dcs_pkg::WM_POWER) | 8'h04;
         if (we_gain)
            output_gain_control <= (wdata & dcs_pkg::WM_GAIN) | 8'h0f;
         if (we_rst)
            delay_loop_restart_control <= wdata & dcs_pkg::WM_RESTART;
      end
   end

   // Flags, synchronisers and sync edge history
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         raw_flags    <= 3'h0;
         error_status <= dcs_pkg::RST_ERR_STAT;
         sync_pin_ff  <= 2'b00;
         clk_pres_ff  <= 2'b00;
         sync_level_q <= 1'b0;
      end else begin
         raw_flags    <= next_raw;
         error_status <= next_error_status;
         sync_pin_ff  <= {sync_pin_ff[0], ext_sync_pin};
         clk_pres_ff  <= {clk_pres_ff[0], source_data_clock_present};
         sync_level_q <= sync_level;
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      case (addr)
         dcs_pkg::OFS_LOCKSTAT: read_mux = {1'b0, delay_loop_locked, 6'h00};
         dcs_pkg::OFS_SYNC_ERR: read_mux = sync_and_error_control;
         dcs_pkg::OFS_ERR_STAT: read_mux = error_status;
         dcs_pkg::OFS_IF_CLK:   read_mux = interface_clocking_control;
         dcs_pkg::OFS_POWER:    read_mux = power_down_control;
         dcs_pkg::OFS_GAIN:     read_mux = output_gain_control;
         dcs_pkg::OFS_RESTART:  read_mux = delay_loop_restart_control;
         default:               read_mux = 8'h00;
      endcase
   end

   // Registered data outputs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata                  <= 8'h00;
         sample_a_out           <= 16'h0000;
         bus_ordered            <= 16'h0000;
         serial_data_output_pin <= 1'b0;
      end else begin
         if (rd_en)
            rdata <= read_mux;
         sample_a_out <= offset_add_enable ?
                         sample_a + {{3{offset_value_a[12]}}, offset_value_a} : sample_a;
         bus_ordered  <= ordered_raw;
         serial_data_output_pin <= selftest_enable ?
                                   error_status[dcs_pkg::B_SELF_FLAG] : serial_out_normal;
      end
   end

   dcs_bit_rev u_rev (
      .enable (bit_order_reverse),
      .din    (in_bus),
      .dout   (ordered_raw)
   );

   dcs_lock_track u_lock (
      .sys_clk      (sys_clk),
      .srst         (srst),
      .restart      (delay_loop_restart),
      .loop_off     (delay_loop_bypass || delay_loop_sleep),
      .clk_present  (clk_pres_ff[1]),
      .locked       (delay_loop_locked),
      .filter_reset (delay_filter_reset),
      .delay_code   (delay_line_code)
   );

   // Checks on flag, mask and control behaviour
   a_flag_sticky: assert property (@(posedge sys_clk) disable iff (srst)
      (raw_flags[1] && !(we_err && !wdata[dcs_pkg::B_OVR_FLAG])) |=> raw_flags[1])
      else $error("overrun flag dropped without clearing write");
   a_flag_clear: assert property (@(posedge sys_clk) disable iff (srst)
      (we_err && !wdata[dcs_pkg::B_OVR_FLAG] && !overrun_event) |=> !raw_flags[1])
      else $error("overrun flag kept after zero write");
   a_overrun_set: assert property (@(posedge sys_clk) disable iff (srst)
      overrun_event |=> raw_flags[1])
      else $error("overrun event lost");
   a_selftest_set: assert property (@(posedge sys_clk) disable iff (srst)
      selftest_fail |=> raw_flags[2])
      else $error("selftest failure lost");

   // Masks hide the visible flags; the checker mask also keeps the raw checker flag from setting
   a_mask_hides: assert property (@(posedge sys_clk) disable iff (srst)
      $past(selftest_fail_mask) |-> !error_status[dcs_pkg::B_SELF_FLAG])
      else $error("masked selftest flag visible");
   a_mask_hides_ovr: assert property (@(posedge sys_clk) disable iff (srst)
      $past(overrun_error_mask) |-> !error_status[dcs_pkg::B_OVR_FLAG])
      else $error("masked overrun flag visible");
   a_mask_hides_chk: assert property (@(posedge sys_clk) disable iff (srst)
      $past(checker_mismatch_mask) |-> !error_status[dcs_pkg::B_CHK_FLAG])
      else $error("masked checker flag visible");
   a_checker_set: assert property (@(posedge sys_clk) disable iff (srst)
      word_bad |=> error_status[dcs_pkg::B_CHK_FLAG] || $past(checker_mismatch_mask) == 1'b0 &&
      checker_mismatch_mask)
      else $error("bad checker word not flagged");
   a_selftest_pin: assert property (@(posedge sys_clk) disable iff (srst)
      selftest_enable |=> serial_data_output_pin == $past(error_status[dcs_pkg::B_SELF_FLAG]))
      else $error("selftest flag not on serial pin");

   // Sync source and divider sync
   a_soft_sync_only: assert property (@(posedge sys_clk) disable iff (srst)
      soft_sync_select |-> tx_enable == soft_sync)
      else $error("external sync leaked through");
   a_soft_sync_level: assert property (@(posedge sys_clk) disable iff (srst)
      soft_sync |-> tx_enable)
      else $error("soft sync did not enable transmit");
   a_sync_one_pulse: assert property (@(posedge sys_clk) disable iff (srst)
      sync_event == $rose(tx_enable))
      else $error("sync event not on rising level");
   a_div_sync_off: assert property (@(posedge sys_clk) disable iff (srst)
      divider_sync_disable |-> !divider_sync)
      else $error("divider sync while disabled");
   a_div_sync_on: assert property (@(posedge sys_clk) disable iff (srst)
      !divider_sync_disable |-> divider_sync == sync_event)
      else $error("divider sync missed");

   // Steered controls follow their register writes
   a_gain_steps: assert property (@(posedge sys_clk) disable iff (srst)
      current_steps == {1'b0, output_current_scale} + 5'h01)
      else $error("gain step count wrong");
   a_gain_write: assert property (@(posedge sys_clk) disable iff (srst)
      we_gain |=> output_current_scale == $past(wdata[7:4]))
      else $error("gain field not taken");
   a_four_wire_write: assert property (@(posedge sys_clk) disable iff (srst)
      we_if |=> four_wire_select == $past(wdata[dcs_pkg::B_FOUR_WIRE]))
      else $error("serial mode select not taken");
   a_bypass_write: assert property (@(posedge sys_clk) disable iff (srst)
      we_if |=> delay_loop_bypass == $past(wdata[dcs_pkg::B_DLY_BYP]) &&
      multiplier_bypass == $past(wdata[dcs_pkg::B_MUL_BYP]))
      else $error("bypass controls not taken");
   a_sleep_write: assert property (@(posedge sys_clk) disable iff (srst)
      we_pwr |=> converter_sleep == $past(wdata[dcs_pkg::B_CNV_SLEEP]) &&
      multiplier_sleep == $past(wdata[dcs_pkg::B_MUL_SLEEP]) &&
      delay_loop_sleep == $past(wdata[dcs_pkg::B_DLY_SLEEP]))
      else $error("sleep controls not taken");
   a_bias_write: assert property (@(posedge sys_clk) disable iff (srst)
      we_pwr |=> bias_filter_select == $past(wdata[dcs_pkg::B_BIAS_SEL]))
      else $error("bias filter select not taken");

   // Datapath hooks
   a_offset_add: assert property (@(posedge sys_clk) disable iff (srst)
      offset_add_enable |=> sample_a_out ==
      16'($past(sample_a) + {{3{$past(offset_value_a[12])}}, $past(offset_value_a)}))
      else $error("offset not added");
   a_offset_off: assert property (@(posedge sys_clk) disable iff (srst)
      !offset_add_enable |=> sample_a_out == $past(sample_a))
      else $error("offset added while disabled");
   a_bus_reversed: assert property (@(posedge sys_clk) disable iff (srst)
      bit_order_reverse |=> bus_ordered[15] == $past(in_bus[0]) &&
      bus_ordered[0] == $past(in_bus[15]))
      else $error("input bus not reversed");
   a_bus_straight: assert property (@(posedge sys_clk) disable iff (srst)
      !bit_order_reverse |=> bus_ordered == $past(in_bus))
      else $error("input bus reordered while straight");

   // Restart steps: held set parks the loop, a release with the loop free starts acquisition
   sequence s_restart_held;
      delay_loop_restart ##1 delay_loop_restart;
   endsequence
   sequence s_loop_parked;
      !delay_loop_locked && delay_filter_reset && delay_line_code == dcs_pkg::DLY_MID;
   endsequence
   sequence s_restart_freed;
      $fell(delay_loop_restart) && !delay_loop_bypass && !delay_loop_sleep && clk_pres_ff[1];
   endsequence
   a_restart_parks: assert property (@(posedge sys_clk) disable iff (srst)
      s_restart_held |-> s_loop_parked)
      else $error("loop not parked during restart");
   a_release_acquires: assert property (@(posedge sys_clk) disable iff (srst)
      s_restart_freed |=> !delay_filter_reset)
      else $error("acquisition did not start after restart");
   a_lock_readback: assert property (@(posedge sys_clk) disable iff (srst)
      (rd_en && addr == dcs_pkg::OFS_LOCKSTAT) |=>
      rdata[dcs_pkg::B_LOCKED] == $past(delay_loop_locked))
      else $error("lock status not read back");
endmodule

// File: test/dcs_host.sv
// Host model driving writes and reads on the configuration port
`timescale 1ns/1ps
module dcs_host (
   input  wire logic       sys_clk,
   output logic            wr_en,
   output logic            rd_en,
   output logic      [3:0] addr,
   output logic      [7:0] wdata,
   input  wire logic [7:0] rdata
);
   // Idle port at time zero
   initial begin
      {wr_en, rd_en} = 2'b00;
      {addr, wdata} = 12'hf00;
   end
   // One write; released lines show the inverse so nothing stale looks valid
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      {wr_en, addr, wdata} = {1'b1, a, d};
      @(posedge sys_clk);
      #1;
      {wr_en, addr, wdata} = {1'b0, ~a, ~d};
   endtask
   // One read; data stands from the edge after the strobe until the next read
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      #1;
      {rd_en, addr} = {1'b1, a};
      @(posedge sys_clk);
      #1;
      {rd_en, addr} = {1'b0, ~a};
      @(posedge sys_clk);
      #1;
      d = rdata;
   endtask
endmodule

// File: test/testbench.sv
// Self-checking bench of the control and status register bank
`timescale 1ns/1ps
module testbench;
   logic        sys_clk, srst, wr_en, rd_en, ext_sync_pin, clk_ok, st_en, st_fail;
   logic        ovr, bw_valid, sync_event, tx_enable, divider_sync, fws, dbyp, mbyp;
   logic        csl, msl, dsl, bias, dfr, ser_out, ser_norm;
   logic [3:0]  addr, scale, dcode, a;
   logic [4:0]  steps;
   logic [7:0]  wdata, rdata, d, s0, d0, n_sync, n_div;
   logic [7:0]  sh [16];
   logic [12:0] offset;
   logic [15:0] buf_word, in_bus, sample_a, bus_ordered, sample_a_out, pins;
   int          error_cnt, total_checks, cyc;

   dcs_regs dut (
      .sys_clk(sys_clk), .srst(srst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata(rdata), .ext_sync_pin(ext_sync_pin),
      .source_data_clock_present(clk_ok), .selftest_enable(st_en),
      .selftest_fail(st_fail), .overrun_event(ovr), .buf_word_valid(bw_valid),
      .buf_word(buf_word), .in_bus(in_bus), .offset_value_a(offset),
      .sample_a(sample_a), .serial_out_normal(ser_norm), .bus_ordered(bus_ordered),
      .sample_a_out(sample_a_out), .sync_event(sync_event), .tx_enable(tx_enable),
      .divider_sync(divider_sync), .four_wire_select(fws), .delay_loop_bypass(dbyp),
      .multiplier_bypass(mbyp), .converter_sleep(csl), .multiplier_sleep(msl),
      .delay_loop_sleep(dsl), .bias_filter_select(bias), .output_current_scale(scale),
      .current_steps(steps), .delay_filter_reset(dfr), .delay_line_code(dcode),
      .serial_data_output_pin(ser_out)
   );
   dcs_host host (
      .sys_clk(sys_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata(rdata)
   );
   // Static control pins gathered for one comparison
   assign pins = {fws, dbyp, mbyp, csl, bias, msl, dsl, scale, steps};

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Sync pulse counters and run limit
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (sync_event === 1'b1)
         n_sync <= n_sync + 8'h01;
      if (divider_sync === 1'b1)
         n_div <= n_div + 8'h01;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      chk_pin({8'h00, got}, {8'h00, exp});
   endtask
   task automatic rchk(input logic [3:0] ra, input logic [7:0] exp);
      logic [7:0] v;
      host.rd(ra, v);
      chk_reg(v, exp);
   endtask
   // Readback value once reserved bits take their fixed levels
   function automatic logic [7:0] exp_reg(input logic [3:0] ra, input logic [7:0] v);
      case (ra)
         4'h5: return v & 8'he6;
         4'h6: return (v & 8'h1b) | 8'h04;
         default: return v | 8'h0f;
      endcase
   endfunction
   function automatic logic [15:0] exp_pins();
      return {sh[5][7], sh[5][2], sh[5][1], sh[6][4], sh[6][3], sh[6][1], sh[6][0],
              sh[7][7:4], 5'(sh[7][7:4]) + 5'h01};
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {srst, ext_sync_pin, clk_ok, st_en, st_fail, ovr, bw_valid, ser_norm} = 8'b10100000;
      {buf_word, in_bus, sample_a, offset} = '0;
      {error_cnt, total_checks, cyc, n_sync, n_div} = '0;
      sh = '{default: 8'h00};
      {sh[6], sh[7]} = 16'h0cff;
      d = 8'($urandom(86552));
      repeat (8) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      rchk(4'h0, 8'h00);
      for (int i = 0; i < 6; i++)
         rchk(4'(3 + i), 8'(48'h70_00_00_0c_ff_00 >> (40 - 8 * i)));
      chk_pin(pins, exp_pins());
      host.wr(4'hf, 8'hff);
      rchk(4'hf, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 30; i++) begin
         a = 4'(5 + i % 3);
         d = (i == 2) ? 8'h00 : 8'($urandom);
         host.wr(a, d);
         sh[a] = exp_reg(a, d);
         rchk(a, sh[a]);
         chk_pin(pins, exp_pins());
      end
      $display("test config done");
      for (int i = 0; i < 2; i++) begin
         host.wr(4'h5, {2'b00, i[0], 5'h00});
         host.wr(4'h3, 8'h70);
         {s0, d0} = {n_sync, n_div};
         host.wr(4'h3, 8'h72);
         repeat (3) tick();
         chk_pin({n_sync - s0, n_div - d0}, {8'h01, 7'h00, ~i[0]});
         chk_pin(16'(tx_enable), 16'h0001);
      end
      host.wr(4'h3, 8'h71);
      s0 = n_sync;
      ext_sync_pin = 1'b1;
      repeat (4) tick();
      chk_pin({7'h00, tx_enable, n_sync - s0}, 16'h0000);
      host.wr(4'h3, 8'h70);
      repeat (4) tick();
      chk_pin(16'(tx_enable), 16'h0001);
      ext_sync_pin = 1'b0;
      $display("test sync done");
      {st_en, st_fail, ovr} = 3'b111;
      tick();
      {st_fail, ovr} = 2'b00;
      rchk(4'h4, 8'h00);
      host.wr(4'h3, 8'h00);
      rchk(4'h4, 8'h60);
      {bw_valid, buf_word} = {1'b1, 16'($urandom) & 16'h7ff0};
      tick();
      {bw_valid, buf_word} = {1'b0, ~buf_word};
      rchk(4'h4, 8'h70);
      chk_pin(16'(ser_out), 16'h0001);
      host.wr(4'h4, 8'hff);
      rchk(4'h4, 8'h70);
      bw_valid = 1'b1;
      for (int i = 0; i < 8; i++) begin
         buf_word = i[0] ? 16'haaaa : 16'h5555;
         tick();
      end
      bw_valid = 1'b0;
      host.wr(4'h4, 8'h00);
      rchk(4'h4, 8'h00);
      chk_pin(16'(ser_out), 16'h0000);
      {st_en, ser_norm} = 2'b01;
      repeat (2) tick();
      chk_pin(16'(ser_out), 16'h0001);
      $display("test flags done");
      for (int i = 0; i < 16; i++) begin
         host.wr(4'h3, {i < 8, 7'h00});
         host.wr(4'h5, {1'b0, i < 8, 6'h00});
         sample_a = 16'($urandom_range(28671, 4096));
         {offset, in_bus} = {13'($urandom), 16'($urandom)};
         repeat (2) tick();
         chk_pin(sample_a_out, sample_a + ((i < 8) ? {{3{offset[12]}}, offset} : 16'h0));
         chk_pin(bus_ordered, (i < 8) ? 16'({<<{in_bus}}) : in_bus);
      end
      $display("test datapath done");
      host.wr(4'h5, 8'h00);
      host.wr(4'h6, 8'h0c);
      host.wr(4'h8, 8'h04);
      tick();
      chk_pin({11'h000, dfr, dcode}, 16'h0018);
      rchk(4'h0, 8'h00);
      host.wr(4'h8, 8'h00);
      repeat (int'(dcs_pkg::LOCK_CYCLES) + 8) tick();
      rchk(4'h0, 8'h40);
      chk_pin(16'(dfr), 16'h0000);
      clk_ok = 1'b0;
      repeat (8) tick();
      rchk(4'h0, 8'h00);
      $display("test restart done");
      tally_and_finish();
   end
endmodule
